// ==== hw/gpr_bank.sv ====
// Paged general purpose register bank with pin, LED, link failure
// and recovered clock control, reached over AXI4-Lite.
// Assumes pins and port status inputs are synchronous to aclk.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "gpr_defines.svh"

module gpr_bank #(
  parameter int LED_N = 4,
  parameter int PORTS = 2
) (
  // Clock, resets, enable
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             power_on_reset_n,
  input  wire logic             ce,
  // AXI4-Lite write address
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Low power hold pin
  input  wire logic             low_power_hold_pin_i,
  output logic                  low_power_hold_pin_o,
  output logic                  low_power_hold_pin_oe,
  // LED pins
  input  wire logic [LED_N-1:0] led_level,
  output logic      [LED_N-1:0] led_o,
  output logic      [LED_N-1:0] led_oe,
  // Link failure
  input  wire logic [PORTS-1:0] port_link_fail,
  output logic                  quick_link_loss_out,
  // Per-port link status for squelch
  input  wire logic [PORTS-1:0] port_link_up,
  input  wire logic [PORTS-1:0] port_link_unstable,
  input  wire logic [PORTS-1:0] port_master_or_10m,
  input  wire logic [PORTS-1:0] port_eee_active,
  input  wire logic [PORTS-1:0] port_lpi_rx,
  // Per-port clock sources
  input  wire logic [PORTS-1:0] port_rcvd_clk,
  input  wire logic [PORTS-1:0] transmitter_clock,
  // Recovered clock
  input  wire logic             clk_mute_in,
  output logic                  recovered_clock_one_out
);

  // Masked write of the low half word
  function automatic logic [15:0] merge_write(
    input logic [15:0] old,
    input logic [31:0] wdata,
    input logic [3:0]  strb,
    input logic [15:0] wmask
  );
    logic [15:0] lane;
    lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~lane) | (wdata[15:0] & lane);
  endfunction

  // Register state
  logic [15:0] page_q;
  logic [15:0] pin_ctrl_q;
  logic [15:0] lf_q;
  logic [15:0] rc_q;
  logic        pin_in_q;

  // Bus state
  logic [4:0]  aw_idx_q;
  logic        aw_hi_q;
  logic        aw_got_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_got_q;
  logic        do_write;
  logic        gp_page;
  logic [4:0]  ar_idx;
  logic [15:0] rd_word;

  assign gp_page  = (page_q == `GPR_PAGE_GP);
  assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign ar_idx   = s_axi_araddr[6:2];

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_got_q      <= 1'b0;
      aw_idx_q      <= 5'd0;
      aw_hi_q       <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got_q      <= 1'b1;
        aw_idx_q      <= s_axi_awaddr[6:2];
        aw_hi_q       <= s_axi_awaddr[7];
      end else if (do_write) begin
        aw_got_q <= 1'b0;
      end else if (!aw_got_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_got_q      <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got_q      <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
      end else if (do_write) begin
        w_got_q <= 1'b0;
      end else if (!w_got_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GPR_RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `GPR_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Page select lives on both pages and clears on ordinary reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_q <= `GPR_PAGE_RST;
    end else if (ce) begin
      if (do_write && !aw_hi_q && aw_idx_q == `GPR_IDX_PAGE) begin
        page_q <= merge_write(page_q, w_data_q, w_strb_q, 16'hffff);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!power_on_reset_n) begin
      pin_ctrl_q <= `GPR_PIN_CTRL_RST;
      lf_q       <= `GPR_LF_RST;
      rc_q       <= `GPR_RC_RST;
    end else if (ce && do_write && !aw_hi_q && gp_page) begin
      unique case (aw_idx_q)
        `GPR_IDX_PIN_CTRL: begin
          pin_ctrl_q <= merge_write(pin_ctrl_q, w_data_q, w_strb_q,
                                    `GPR_PIN_CTRL_WMASK);
        end
        `GPR_IDX_LINK_FAIL: begin
          lf_q <= merge_write(lf_q, w_data_q, w_strb_q, `GPR_LF_WMASK);
        end
        `GPR_IDX_RCLK1: begin
          rc_q <= merge_write(rc_q, w_data_q, w_strb_q, `GPR_RC_WMASK);
        end
        default: begin
        end
      endcase
    end
  end

  // Read word mux
  always_comb begin
    rd_word = 16'h0000;
    if (!s_axi_araddr[7]) begin
      if (ar_idx == `GPR_IDX_PAGE) begin
        rd_word = page_q;
      end else if (gp_page) begin
        unique case (ar_idx)
          `GPR_IDX_PIN_CTRL: begin
            rd_word = pin_ctrl_q;
            rd_word[`GPR_PIN_IN_BIT] = pin_in_q;
          end
          `GPR_IDX_LINK_FAIL: rd_word = lf_q;
          `GPR_IDX_RCLK1:     rd_word = rc_q;
          default:            rd_word = 16'h0000;
        endcase
      end
    end
  end

  // Read channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `GPR_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_word};
        s_axi_rresp   <= `GPR_RESP_OKAY;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Hold pin and LED drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_in_q              <= 1'b0;
      low_power_hold_pin_o  <= 1'b0;
      low_power_hold_pin_oe <= 1'b0;
      led_o                 <= '0;
      led_oe                <= '0;
    end else if (ce) begin
      pin_in_q              <= low_power_hold_pin_i;
      low_power_hold_pin_oe <= ~pin_ctrl_q[`GPR_PIN_DIR_BIT];
      low_power_hold_pin_o  <= pin_ctrl_q[`GPR_PIN_OUT_BIT];
      led_o                 <= led_level;
      if (pin_ctrl_q[`GPR_LED_TRI_BIT]) begin
        led_oe <= ~led_level;
      end else begin
        led_oe <= '1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quick_link_loss_out <= 1'b0;
    end else if (ce) begin
      unique case (lf_q[`GPR_LF_SEL_LSB +: 2])
        2'b00:   quick_link_loss_out <= port_link_fail[0];
        2'b01:   quick_link_loss_out <= port_link_fail[1];
        default: quick_link_loss_out <= 1'b0;
      endcase
    end
  end

  // Recovered clock path
  logic [3:0]           rc_src;
  logic [2:0]           rc_sel;
  logic [2:0]           rc_freq;
  logic [1:0]           rc_sq;
  logic                 src_ok;
  logic                 p;
  logic                 src_level;
  logic                 squelch;
  logic                 div_clk;

  assign rc_src  = rc_q[`GPR_RC_SRC_LSB +: 4];
  assign rc_sel  = rc_q[`GPR_RC_SEL_LSB +: 3];
  assign rc_freq = rc_q[`GPR_RC_FREQ_LSB +: 3];
  assign rc_sq   = rc_q[`GPR_RC_SQ_LSB +: 2];

  always_comb begin
    src_ok = (rc_src == 4'h0) || (rc_src == 4'h1);
    p      = rc_src[0];
    unique case (rc_sel)
      gpr_pkg::GPR_CS_RCVD: src_level = port_rcvd_clk[p];
      gpr_pkg::GPR_CS_TX:   src_level = transmitter_clock[p];
      default:              src_level = 1'b0;
    endcase
    unique case (gpr_pkg::gpr_squelch_e'(rc_sq))
      gpr_pkg::GPR_SQ_STRICT: squelch = ~port_link_up[p] |
        port_link_unstable[p] | port_master_or_10m[p] |
        port_eee_active[p];
      gpr_pkg::GPR_SQ_RELAXED: squelch = ~port_link_up[p] |
        port_link_unstable[p] | (port_eee_active[p] & ~port_lpi_rx[p]);
      gpr_pkg::GPR_SQ_LINKDOWN: squelch = ~port_link_up[p];
      gpr_pkg::GPR_SQ_OFF: squelch = 1'b0;
    endcase
    if (clk_mute_in || !src_ok) begin
      squelch = 1'b1;
    end
  end

  gpr_rclk_div u_div (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .src_level (src_level),
    .freq_code (rc_freq),
    .clk_out   (div_clk)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      recovered_clock_one_out <= 1'b0;
    end else if (ce) begin
      recovered_clock_one_out <= rc_q[`GPR_RC_EN_BIT] & div_clk & ~squelch;
    end
  end

endmodule

// ==== hw/gpr_defines.svh ====
// Offsets, field positions, reset values and frequencies of the general
// purpose register bank. Definitions only; included by bare name.
`ifndef GPR_DEFINES_SVH
`define GPR_DEFINES_SVH

// Register indices; byte address is four times the index
`define GPR_IDX_PAGE          5'h1f
`define GPR_IDX_PIN_CTRL      5'h0e
`define GPR_IDX_LINK_FAIL     5'h13
`define GPR_IDX_RCLK1         5'h17

// Page select codes
`define GPR_PAGE_MAIN         16'h0000
`define GPR_PAGE_GP           16'h0010
`define GPR_PAGE_RST          16'h0000

// Pin control fields
`define GPR_PIN_DIR_BIT       13
`define GPR_PIN_OUT_BIT       12
`define GPR_PIN_IN_BIT        11
`define GPR_LED_TRI_BIT       9
`define GPR_PIN_CTRL_RST      16'h2200
`define GPR_PIN_CTRL_WMASK    16'hf200

// Link failure source field
`define GPR_LF_SEL_LSB        0
`define GPR_LF_RST            16'h0003
`define GPR_LF_WMASK          16'h0003

// Recovered clock one fields
`define GPR_RC_EN_BIT         15
`define GPR_RC_SRC_LSB        11
`define GPR_RC_FREQ_LSB       8
`define GPR_RC_SQ_LSB         4
`define GPR_RC_SEL_LSB        0
`define GPR_RC_RST            16'h0000
`define GPR_RC_WMASK          16'hff37

// Source and output frequencies in hundredths of a MHz, from a 125 MHz source
`define GPR_SRC_MHZ_X100      15'd12500
`define GPR_OUT25_MHZ_X100    15'd2500
`define GPR_OUT31_MHZ_X100    15'd3125

// AXI responses
`define GPR_RESP_OKAY         2'b00

`endif

// ==== hw/gpr_pkg.sv ====
// Types shared by the general purpose register bank.
// Assumes gpr_defines.svh supplies the numeric constants.
package gpr_pkg;

  typedef enum logic [1:0] {
    GPR_SQ_STRICT   = 2'b00,
    GPR_SQ_RELAXED  = 2'b01,
    GPR_SQ_LINKDOWN = 2'b10,
    GPR_SQ_OFF      = 2'b11
  } gpr_squelch_e;

  typedef enum logic [2:0] {
    GPR_F_25M  = 3'b000,
    GPR_F_125M = 3'b001,
    GPR_F_31M  = 3'b010
  } gpr_freq_e;

  typedef enum logic [2:0] {
    GPR_CS_RCVD = 3'b001,
    GPR_CS_TX   = 3'b010
  } gpr_clksel_e;

endpackage

// ==== hw/gpr_rclk_div.sv ====
// Divider for the recovered clock output.
// Assumes the source arrives as a level synchronous to aclk.
`timescale 1ns/1ps
`include "gpr_defines.svh"

module gpr_rclk_div (
  // Clock, reset, enable
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Source and setting
  input  wire logic       src_level,
  input  wire logic [2:0] freq_code,
  // Divided level
  output logic            clk_out
);

  localparam logic [2:0] DIV25 =
    3'(`GPR_SRC_MHZ_X100 / `GPR_OUT25_MHZ_X100);
  localparam logic [2:0] DIV31 =
    3'(`GPR_SRC_MHZ_X100 / `GPR_OUT31_MHZ_X100);

  logic       src_q;
  logic [2:0] cnt_q;
  logic [2:0] div;
  logic [2:0] cnt_d;
  logic       rise;

  always_comb begin
    div = (freq_code == gpr_pkg::GPR_F_31M) ? DIV31 : DIV25;
    rise = src_level & ~src_q;
    cnt_d = cnt_q;
    if (rise) begin
      cnt_d = (cnt_q >= div - 3'd1) ? 3'd0 : cnt_q + 3'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= 1'b0;
      cnt_q <= 3'd0;
    end else if (ce) begin
      src_q <= src_level;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_out <= 1'b0;
    end else if (ce) begin
      if (freq_code == gpr_pkg::GPR_F_125M) begin
        clk_out <= src_level;
      end else if (freq_code == gpr_pkg::GPR_F_25M ||
                   freq_code == gpr_pkg::GPR_F_31M) begin
        clk_out <= (cnt_d < (div >> 1));
      end else begin
        clk_out <= 1'b0;
      end
    end
  end

endmodule

// ==== test/gpr_bank_assertions.sv ====
// Checker of bus handshakes, LED follow and mute on the register bank.
// Assumes ce is high around traffic and sees only the bank's ports.
`timescale 1ns/1ps

module gpr_bank_chk #(
  parameter int LED_N = 4
) (
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Bus
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  // Pins
  input wire logic [LED_N-1:0] led_level,
  input wire logic [LED_N-1:0] led_o,
  input wire logic             clk_mute_in,
  input wire logic             recovered_clock_one_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_b;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid && s_axi_bresp == 2'b00;
  endproperty
  a_b: assert property (p_b) else $error("write answer late");
  property p_b_gap;
    s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready);
  endproperty
  a_b_gap: assert property (p_b_gap) else $error("write idle bad");
  property p_aw_once;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_once: assert property (p_aw_once) else $error("awready held");
  property p_w_once;
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready;
  endproperty
  a_w_once: assert property (p_w_once) else $error("wready held");
  property p_r;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r: assert property (p_r) else $error("read answer late");
  property p_r_word;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rresp == 2'b00;
  endproperty
  a_r_word: assert property (p_r_word) else $error("read word bad");
  property p_r_gap;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready;
  endproperty
  a_r_gap: assert property (p_r_gap) else $error("read idle bad");
  property p_mute;
    clk_mute_in [*4] |-> !recovered_clock_one_out;
  endproperty
  a_mute: assert property (p_mute) else $error("clock not muted");
  property p_led;
    $past(aresetn) |-> led_o == $past(led_level);
  endproperty
  a_led: assert property (p_led) else $error("led level lost");

  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_mute: cover property (clk_mute_in [*4]);
endmodule

// ==== test/gpr_sync_timer.sv ====
// Board timing circuit: drives the mute pin and counts recovered clock.
// Assumes the recovered clock is a level sampled on aclk.
`timescale 1ns/1ps

module gpr_sync_timer (
  // Clock
  input  wire logic aclk,
  // Bench control
  input  wire logic mute_req,
  input  wire logic clr,
  // Clock side
  input  wire logic rclk,
  output logic      clk_mute,
  output logic [7:0] rise_cnt
);
  logic rclk_q;

  always_ff @(posedge aclk) clk_mute <= mute_req;

  always_ff @(posedge aclk) begin
    rclk_q <= rclk;
    if (clr) rise_cnt <= 8'h00;
    else if (rclk && !rclk_q) rise_cnt <= rise_cnt + 8'h01;
  end
endmodule

// ==== test/tb_top.sv ====
// Bench of the paged register bank over AXI4-Lite.
// Assumes bank, checker and timing model compiled before it.
`timescale 1ns/1ps

module tb_top;
  logic        aclk, aresetn, por_n, ce, tgl, mute_req, clr, done;
  logic [7:0]  awaddr, araddr, cnt;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb, led_lv, led_o, led_oe;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, lfail, lup, mst, src, cls, unst, eee, lpi;
  logic        pin_i, pin_o, pin_oe, pin_ext, qll, rco, mute_in;
  logic [4:0]  rsv [5] = '{5'h00, 5'h0d, 5'h0f, 5'h12, 5'h1e};
  logic [15:0] rcv [18] = '{16'h0131, 16'h8131, 16'h8131, 16'h8131,
    16'h8121, 16'h8121, 16'h8101, 16'h8111, 16'h8031, 16'h8231,
    16'h8132, 16'h8931, 16'h8101, 16'h8111, 16'h8111, 16'h8111,
    16'h9131, 16'h8133};
  // Per case: unstable, eee, idle rx, class, mute, link up, master
  logic [7:0]  rcf [18] = '{8'h02, 8'h12, 8'h10, 8'h06, 8'h00, 8'h12,
    8'h03, 8'h13, 8'h0a, 8'h0a, 8'h12, 8'h02, 8'h42, 8'h82, 8'h72,
    8'h42, 8'h02, 8'h02};
  int          n_fail, samples_checked;

  assign pin_i = pin_oe ? pin_o : pin_ext;
  assign src = {1'b0, tgl};

  gpr_bank i_gpr_bank (.aclk(aclk), .aresetn(aresetn),
    .power_on_reset_n(por_n), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .low_power_hold_pin_i(pin_i), .low_power_hold_pin_o(pin_o),
    .low_power_hold_pin_oe(pin_oe), .led_level(led_lv), .led_o(led_o),
    .led_oe(led_oe), .port_link_fail(lfail), .quick_link_loss_out(qll),
    .port_link_up(lup), .port_link_unstable(unst),
    .port_master_or_10m(mst), .port_eee_active(eee),
    .port_lpi_rx(lpi), .port_rcvd_clk(src), .transmitter_clock(src),
    .clk_mute_in(mute_in), .recovered_clock_one_out(rco));

  gpr_sync_timer i_gpr_sync_timer (.aclk(aclk), .mute_req(mute_req),
    .clr(clr), .rclk(rco), .clk_mute(mute_in), .rise_cnt(cnt));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) tgl <= ~tgl;

  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    int t;
    @(posedge aclk);
    awaddr <= {1'b0, idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    for (t = 0; t < 50 && !done; t++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    check("write done", 32'(done), 32'h1);
  endtask

  task automatic rc(input logic [4:0] idx, input logic [15:0] e);
    int t;
    @(posedge aclk);
    araddr <= {1'b0, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    v = 32'hdead0000;
    for (t = 0; t < 50 && !done; t++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    check($sformatf("reg %h", idx), v, {16'h0000, e});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100us;
    n_fail++;
    give_verdict();
  end

  initial begin
    n_fail = 0;
    samples_checked = 0;
    {aresetn, por_n, tgl, mute_req, clr, awvalid, wvalid} = '0;
    {bready, arvalid, rready, awaddr, araddr, wdata, lfail, mst} = '0;
    {unst, eee, lpi} = '0;
    {ce, wstrb, lup, pin_ext, led_lv} = {1'b1, 4'hf, 2'b11, 1'b1, 4'ha};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    rc(5'h0e, 16'h0000); // main page hides
    wr(5'h1f, 16'h0010);
    rc(5'h1f, 16'h0010); // page held
    rc(5'h0e, 16'h2a00); // reset value
    check("pin oe", 32'(pin_oe), 32'h0); // input at reset
    check("led oe", 32'(led_oe), 32'h5); // drive low only
    rc(5'h13, 16'h0003); // reset value
    rc(5'h17, 16'h0000); // reset value
    foreach (rsv[k]) begin
      wr(rsv[k], 16'hffff);
      rc(rsv[k], 16'h0000); // reads zero
    end
    wr(5'h0e, 16'hffff);
    rc(5'h0e, 16'hfa00); // read-only bits kept
    wr(5'h0e, 16'h1000);
    rc(5'h0e, 16'h1800); // pin driven high
    check("pin drive", 32'({pin_oe, pin_o}), 32'h3); // output
    check("led drive", 32'({led_oe, led_o}), 32'hfa); // both levels
    wr(5'h0e, 16'h0000);
    rc(5'h0e, 16'h0000); // pin driven low
    wr(5'h0e, 16'h1000);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(5'h1f, 16'h0000); // page cleared
    wr(5'h1f, 16'h0010);
    rc(5'h0e, 16'h1800); // survives reset
    for (int s = 0; s < 4; s++) begin
      wr(5'h13, 16'(s));
      rc(5'h13, 16'(s)); // field stored
      for (int p = 1; p < 3; p++) begin
        @(posedge aclk);
        lfail <= 2'(p);
        repeat (3) @(posedge aclk);
        check("link loss", 32'(qll), 32'(s < 2 ? (p >> s) & 1 : 0));
      end
    end
    // Low enable freezes the failure output
    wr(5'h13, 16'h0000);
    lfail <= 2'b01;
    repeat (3) @(posedge aclk);
    ce <= 1'b0;
    lfail <= 2'b00;
    repeat (3) @(posedge aclk);
    check("ce hold", 32'(qll), 32'h1);
    ce <= 1'b1;
    repeat (3) @(posedge aclk);
    check("ce run", 32'(qll), 32'h0);
    for (int k = 0; k < 18; k++) begin
      wr(5'h17, rcv[k]);
      rc(5'h17, rcv[k]); // field stored
      @(posedge aclk);
      mute_req <= rcf[k][2];
      lup <= {2{rcf[k][1]}};
      mst <= {2{rcf[k][0]}};
      unst <= {2{rcf[k][7]}};
      eee <= {2{rcf[k][6]}};
      lpi <= {2{rcf[k][5]}};
      repeat (8) @(posedge aclk);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      repeat (60) @(posedge aclk);
      cls = cnt == 8'h00 ? 2'd0 : (cnt < 8'd12 ? 2'd1 : 2'd2);
      check("rclk", 32'(cls), 32'(rcf[k][4:3])); // clock
    end
    give_verdict();
  end
endmodule

bind gpr_bank gpr_bank_chk #(.LED_N(LED_N)) i_gpr_bank_chk (.*);
